// ==== logic/sgcm_manager.sv ====
// Overview of operation
// - Closed-position input true means the unit reports closed.
// - Open-position input true means the unit reports open.
// - Earthing units use the earth input as second position and flag earthed.
// - Ready input is passed out as breaker-ready for other functions.
// - Each unit has a removed input reported for withdrawn breakers.
// - Each unit has its own configurable close travel supervision time.
// - Each unit has its own configurable open travel supervision time.
// - Any of three close-blocking signals rejects a close command.
// - Any of three open-blocking signals rejects an open command.
// - An external signal requests closing a controlled unit.
// - A second external signal requests opening a controlled unit.
// - Each output relay has seven slots carrying any unit close or open command.
// - Protection trips act only on units with break capability.
// - Unit one must keep break capability; other configurations are refused.
// - Manual and external commands act only on controlled units.
// - Break-capable uncontrolled units take trips but refuse manual commands.
// - Units with neither property are only monitored, never commanded.
// - Units are addressed by sequence number, not by name.
// - Closed, open, intermediate and faulty positions are reported distinctly.
// - Position code is 0 intermediate, 1 open, 2 closed, 3 disturbed.
//
// The address map and the APB register port were chosen for this implementation.
module sgcm_manager #(
    parameter int unsigned TICK_CYCLES = sgcm_pkg::MOVE_TICK_CYCLES
) (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [7:0]                           paddr,
    input  wire logic [31:0]                          pwdata,
    output logic [31:0]                               prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [sgcm_pkg::NU-1:0]              aux_closed_input,
    input  wire logic [sgcm_pkg::NU-1:0]              aux_open_input,
    input  wire logic [sgcm_pkg::NU-1:0]              ready_input,
    input  wire logic [sgcm_pkg::NU-1:0]              removed_input,
    input  wire logic [sgcm_pkg::NU*sgcm_pkg::NBLK-1:0] close_block_input,
    input  wire logic [sgcm_pkg::NU*sgcm_pkg::NBLK-1:0] open_block_input,
    input  wire logic [sgcm_pkg::NU-1:0]              external_close_request,
    input  wire logic [sgcm_pkg::NU-1:0]              external_open_request,
    input  wire logic [sgcm_pkg::NU-1:0]              protection_trip,
    output logic [2*sgcm_pkg::NU-1:0]                 position_code,
    output logic [sgcm_pkg::NU-1:0]                   unit_ready,
    output logic [sgcm_pkg::NU-1:0]                   unit_removed,
    output logic [sgcm_pkg::NU-1:0]                   unit_earthed,
    output logic [sgcm_pkg::NU-1:0]                   close_cmd,
    output logic [sgcm_pkg::NU-1:0]                   open_cmd,
    output logic [sgcm_pkg::NR-1:0]                   relay_out
);
    import sgcm_pkg::*;

    typedef struct packed {
        logic [NU-1:0]                   cfg_break;
        logic [NU-1:0]                   cfg_ctrl;
        logic [NU-1:0]                   cfg_earth;
        logic [NU-1:0][15:0]             tmove_on;
        logic [NU-1:0][15:0]             tmove_off;
        logic [NR-1:0][NSLOT-1:0][3:0]   relay_asg;
        logic [1:0]                      unit_sel;
        sgcm_move_e [NU-1:0]             move;
        logic [NU-1:0][15:0]             timer;
        logic [NU-1:0]                   fault;
        logic [NU-1:0][1:0]              pos;
        logic [NU-1:0]                   ready;
        logic [NU-1:0]                   removed;
        logic [NU-1:0]                   earthed;
        logic [NU-1:0]                   ext_on_q;
        logic [NU-1:0]                   ext_off_q;
        logic [NU-1:0]                   trip_q;
        logic [NU-1:0]                   ev_timeout;
        logic [NU-1:0]                   ev_reject;
        logic                            ev_cfg;
        logic [NR-1:0]                   relay;
        logic [NU-1:0]                   cmd_close;
        logic [NU-1:0]                   cmd_open;
        logic [15:0]                     tick_cnt;
        logic                            tick;
        logic [31:0]                     prdata;
        logic                            pready;
        logic                            pslverr;
    } sgcm_state_s;

    sgcm_state_s s;
    sgcm_state_s next_s;

    // Next-state logic for the bus slave, the travel supervision and the relays.
    always_comb begin
        logic          acc;
        logic          wr;
        logic          hit;
        logic [31:0]   rd;
        logic [1:0]    idx;
        logic          closed;
        logic          other;
        logic          go_close;
        logic          go_open;
        logic          cblk;
        logic          oblk;
        logic [NU-1:0] ccmd;
        logic [NU-1:0] ocmd;
        logic [3:0]    sel;
        acc      = 1'b0;
        wr       = 1'b0;
        hit      = 1'b1;
        rd       = 32'h0;
        idx      = paddr[3:2];
        closed   = 1'b0;
        other    = 1'b0;
        go_close = 1'b0;
        go_open  = 1'b0;
        cblk     = 1'b0;
        oblk     = 1'b0;
        ccmd     = '0;
        ocmd     = '0;
        sel      = 4'h0;
        next_s   = s;

        // The answer is registered, so every transfer takes exactly one wait-free access cycle.
        acc = psel && penable && s.pready;
        if (paddr[7:4] == TMOVE_PAGE) begin
            rd = {s.tmove_off[idx], s.tmove_on[idx]};
        end else if (paddr[7:4] == RELAY_PAGE) begin
            rd = {4'h0, s.relay_asg[idx]};
        end else begin
            case (paddr)
                CFG_OFS:    rd = {20'h0, s.cfg_earth, s.cfg_ctrl, s.cfg_break};
                CMD_OFS:    rd = 32'h0;
                STATUS_OFS: rd = {12'h0, s.earthed, s.removed, s.ready, s.pos};
                EVENT_OFS:  rd = {23'h0, s.ev_cfg, s.ev_reject, s.ev_timeout};
                USEL_OFS:   rd = {30'h0, s.unit_sel};
                // Sequence number of the selected unit rides with its state.
                UPOS_OFS:   rd = {24'h0, 2'h0, s.unit_sel, s.removed[s.unit_sel],
                                  s.ready[s.unit_sel], s.pos[s.unit_sel]};
                default:    hit = 1'b0;
            endcase
        end
        wr = acc && pwrite && hit;
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !hit;
        next_s.prdata  = (psel && !penable && !pwrite && hit) ? rd : 32'h0;

        // Register writes; the event clear comes first so that a same-cycle set wins.
        if (wr && paddr == EVENT_OFS) begin
            next_s.ev_timeout = s.ev_timeout & ~pwdata[NU-1:0];
            next_s.ev_reject  = s.ev_reject & ~pwdata[EV_REJ_LSB +: NU];
            next_s.ev_cfg     = s.ev_cfg & ~pwdata[EV_CFG_BIT];
        end
        if (wr && paddr == CFG_OFS) begin
            if (pwdata[CFG_BREAK_LSB]) begin
                next_s.cfg_break = pwdata[CFG_BREAK_LSB +: NU];
                next_s.cfg_ctrl  = pwdata[CFG_CTRL_LSB +: NU];
                next_s.cfg_earth = pwdata[CFG_EARTH_LSB +: NU];
            end else begin
                next_s.ev_cfg = 1'b1;
            end
        end
        if (wr && paddr == USEL_OFS) begin
            next_s.unit_sel = pwdata[1:0];
        end
        if (wr && paddr[7:4] == TMOVE_PAGE) begin
            next_s.tmove_on[idx]  = pwdata[15:0];
            next_s.tmove_off[idx] = pwdata[31:16];
        end
        if (wr && paddr[7:4] == RELAY_PAGE) begin
            next_s.relay_asg[idx] = pwdata[4*NSLOT-1:0];
        end

        // Millisecond enable for the travel timers.
        next_s.tick     = (s.tick_cnt == 16'(TICK_CYCLES - 1));
        next_s.tick_cnt = next_s.tick ? 16'h0 : s.tick_cnt + 16'h1;

        // Per-unit position evaluation and travel supervision.
        for (int u = 0; u < NU; u++) begin
            closed = aux_closed_input[u];
            other  = aux_open_input[u]; // Earth input on earthing units.
            cblk   = |close_block_input[NBLK*u +: NBLK];
            oblk   = |open_block_input[NBLK*u +: NBLK];
            next_s.ext_on_q[u]  = external_close_request[u];
            next_s.ext_off_q[u] = external_open_request[u];
            next_s.trip_q[u]    = protection_trip[u];
            // Manual and external requests need the controlled property.
            go_close = s.cfg_ctrl[u] && ((wr && paddr == CMD_OFS && pwdata[u])
                       || (external_close_request[u] && !s.ext_on_q[u]));
            go_open  = (s.cfg_ctrl[u] && ((wr && paddr == CMD_OFS && pwdata[CMD_OPEN_LSB + u])
                       || (external_open_request[u] && !s.ext_off_q[u])))
                       || (s.cfg_break[u] && protection_trip[u] && !s.trip_q[u]);
            if ((go_close && cblk) || (go_open && oblk)) begin
                next_s.ev_reject[u] = 1'b1;
            end
            // A clean end position clears any earlier travel fault.
            if (closed != other) begin
                next_s.fault[u] = 1'b0;
            end
            // Timeouts are judged on a tick only, so a move always gets its full set time.
            case (s.move[u])
                SGCM_IDLE: begin
                    if (go_open && !oblk) begin
                        next_s.move[u]  = SGCM_OPENING;
                        next_s.timer[u] = 16'h0;
                    end else if (go_close && !cblk) begin
                        next_s.move[u]  = SGCM_CLOSING;
                        next_s.timer[u] = 16'h0;
                    end
                end
                SGCM_CLOSING: begin
                    if (go_open && !oblk) begin
                        // An open request, a trip above all, aborts a close in progress.
                        next_s.move[u]  = SGCM_OPENING;
                        next_s.timer[u] = 16'h0;
                    end else if (closed && !other) begin
                        next_s.move[u] = SGCM_IDLE;
                    end else if (s.tick && s.timer[u] >= s.tmove_on[u]) begin
                        next_s.move[u]       = SGCM_IDLE;
                        next_s.fault[u]      = 1'b1;
                        next_s.ev_timeout[u] = 1'b1;
                    end else if (s.tick) begin
                        next_s.timer[u] = s.timer[u] + 16'h1;
                    end
                end
                SGCM_OPENING: begin
                    if (other && !closed) begin
                        next_s.move[u] = SGCM_IDLE;
                    end else if (s.tick && s.timer[u] >= s.tmove_off[u]) begin
                        next_s.move[u]       = SGCM_IDLE;
                        next_s.fault[u]      = 1'b1;
                        next_s.ev_timeout[u] = 1'b1;
                    end else if (s.tick) begin
                        next_s.timer[u] = s.timer[u] + 16'h1;
                    end
                end
                default: next_s.move[u] = SGCM_IDLE;
            endcase
            // Monitor-only units never drive a coil, even after a reconfiguration.
            if (!s.cfg_ctrl[u] && !s.cfg_break[u]) begin
                next_s.move[u] = SGCM_IDLE;
            end
            ccmd[u] = (next_s.move[u] == SGCM_CLOSING);
            ocmd[u] = (next_s.move[u] == SGCM_OPENING);
            // Coil commands are registered so the pins never glitch on a state decode.
            next_s.cmd_close[u] = ccmd[u];
            next_s.cmd_open[u]  = ocmd[u];
            // Position code; a latched travel fault reads as disturbed.
            if (closed && other) begin
                next_s.pos[u] = POS_DISTURB;
            end else if (closed) begin
                next_s.pos[u] = POS_CLOSED;
            end else if (other) begin
                next_s.pos[u] = POS_OPEN;
            end else if (next_s.fault[u]) begin
                next_s.pos[u] = POS_DISTURB;
            end else begin
                next_s.pos[u] = POS_INDET;
            end
            next_s.earthed[u] = s.cfg_earth[u] && other && !closed;
            next_s.ready[u]   = ready_input[u];
            next_s.removed[u] = removed_input[u];
        end

        // Each relay ORs the commands its seven slots select; code 0 is an empty slot.
        for (int r = 0; r < NR; r++) begin
            next_s.relay[r] = 1'b0;
            for (int k = 0; k < NSLOT; k++) begin
                sel = s.relay_asg[r][k] - 4'h1;
                if (s.relay_asg[r][k] != 4'h0 && s.relay_asg[r][k] <= 4'(2 * NU)) begin
                    next_s.relay[r] = next_s.relay[r]
                                      | (sel[0] ? ocmd[sel[2:1]] : ccmd[sel[2:1]]);
                end
            end
        end
    end

    // State register; unit one starts with break capability and never loses it, since writes clearing it are refused.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s           <= '0;
            s.cfg_break <= CFG_BREAK_RST;
            s.cfg_ctrl  <= CFG_CTRL_RST;
            s.tmove_on  <= {NU{TMOVE_ON_RST}};
            s.tmove_off <= {NU{TMOVE_OFF_RST}};
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign position_code = s.pos;
    assign unit_ready    = s.ready;
    assign unit_removed  = s.removed;
    assign unit_earthed  = s.earthed;
    assign relay_out     = s.relay;
    assign close_cmd     = s.cmd_close;
    assign open_cmd      = s.cmd_open;

    // Checks on the behaviour of units 0 to 3.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pos_closed_a: assert property (aux_closed_input[0] && !aux_open_input[0]
        |=> position_code[1:0] == POS_CLOSED) else $error("closed input not reported");
    pos_open_a: assert property (aux_open_input[0] && !aux_closed_input[0]
        |=> position_code[1:0] == POS_OPEN) else $error("open input not reported");
    earth_flag_a: assert property (s.cfg_earth[3] && aux_open_input[3]
        && !aux_closed_input[3] |=> unit_earthed[3]) else $error("earth position not flagged");
    ready_pass_a: assert property (ready_input[2]
        |=> unit_ready[2]) else $error("ready not passed out");
    removed_pass_a: assert property (removed_input[2] ##1 removed_input[2]
        |-> unit_removed[2]) else $error("removed not passed out");
    close_block_a: assert property ((|close_block_input[2:0])
        && s.move[0] == SGCM_IDLE |=> s.move[0] != SGCM_CLOSING)
        else $error("blocked close started");
    open_block_a: assert property ((|open_block_input[2:0])
        && s.move[0] != SGCM_OPENING |=> s.move[0] != SGCM_OPENING)
        else $error("blocked open started");
    unit_one_a: assert property (s.cfg_break[0])
        else $error("unit one lost break capability");
    manual_refused_a: assert property (!s.cfg_ctrl[1] && s.move[1] == SGCM_IDLE
        |=> s.move[1] != SGCM_CLOSING) else $error("uncontrolled unit closed");
    monitor_only_a: assert property (!s.cfg_ctrl[1] && !s.cfg_break[1]
        |=> !close_cmd[1] && !open_cmd[1]) else $error("monitored unit commanded");
    timeout_pos_a: assert property ($rose(s.ev_timeout[0]) && !aux_closed_input[0]
        && !aux_open_input[0] |=> position_code[1:0] == POS_DISTURB)
        else $error("timeout not disturbed");
    // A fresh trip on a break-capable unit must open it unless an open blocker stands.
    trip_open_a: assert property (s.cfg_break[1] && s.move[1] != SGCM_OPENING
        && $rose(protection_trip[1]) && !(|open_block_input[5:3])
        |=> open_cmd[1]) else $error("trip on break unit ignored");
    relay_slot_a: assert property (s.relay_asg[0][0] == 4'h1
        && $stable(s.relay_asg[0][0]) && close_cmd[0] |-> relay_out[0])
        else $error("relay slot not driven");

    close_done_c: cover property (close_cmd[0] ##[1:100] !close_cmd[0]
        && position_code[1:0] == POS_CLOSED);
    timeout_c: cover property ($rose(s.ev_timeout[0]));
    reject_c: cover property ($rose(s.ev_reject[0]));
    trip_c: cover property ($rose(protection_trip[0]) ##1 open_cmd[0]);
    earth_c: cover property (unit_earthed[3]);

endmodule : sgcm_manager

// ==== logic/sgcm_pkg.sv ====
package sgcm_pkg;

    // Size of the manager: switching units and binary output relays.
    localparam int NU          = 4;
    localparam int NR          = 4;
    localparam int NSLOT       = 7;
    localparam int NBLK        = 3;

    // Clock and travel-timer base; the timers count whole milliseconds.
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MOVE_TICK_NS     = 1000000;
    localparam int MOVE_TICK_CYCLES = MOVE_TICK_NS / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] CFG_OFS    = 8'h00;
    localparam logic [7:0] CMD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] EVENT_OFS  = 8'h0c;
    localparam logic [7:0] USEL_OFS   = 8'h10;
    localparam logic [7:0] UPOS_OFS   = 8'h14;
    localparam logic [3:0] TMOVE_PAGE = 4'h2;
    localparam logic [3:0] RELAY_PAGE = 4'h4;

    // Field positions.
    localparam int CFG_BREAK_LSB = 0;
    localparam int CFG_CTRL_LSB  = 4;
    localparam int CFG_EARTH_LSB = 8;
    localparam int CMD_OPEN_LSB  = 4;
    localparam int EV_REJ_LSB    = 4;
    localparam int EV_CFG_BIT    = 8;

    // Reset values.
    localparam logic [NU-1:0] CFG_BREAK_RST = 4'h1;
    localparam logic [NU-1:0] CFG_CTRL_RST  = 4'h1;
    localparam logic [15:0]   TMOVE_ON_RST  = 16'h00c8;
    localparam logic [15:0]   TMOVE_OFF_RST = 16'h00c8;

    // Position codes.
    localparam logic [1:0] POS_INDET   = 2'h0;
    localparam logic [1:0] POS_OPEN    = 2'h1;
    localparam logic [1:0] POS_CLOSED  = 2'h2;
    localparam logic [1:0] POS_DISTURB = 2'h3;

    // Travel state of a unit.
    typedef enum logic [1:0] {
        SGCM_IDLE    = 2'b00,
        SGCM_CLOSING = 2'b01,
        SGCM_OPENING = 2'b10
    } sgcm_move_e;

endpackage : sgcm_pkg

// ==== tb/sgcm_gear.sv ====
// Behavioural switchgear: travels a fixed time per move and can stick mid-travel.
module sgcm_gear #(
    parameter int DELAY = 20
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [sgcm_pkg::NU-1:0] close_cmd,
    input  wire logic [sgcm_pkg::NU-1:0] open_cmd,
    input  wire logic [sgcm_pkg::NU-1:0] stall,
    output logic      [sgcm_pkg::NU-1:0] aux_closed,
    output logic      [sgcm_pkg::NU-1:0] aux_open
);
    timeunit 1ns;
    timeprecision 1ns;
    import sgcm_pkg::*;

    int cnt [NU];

    // Both contacts release while moving, so a stuck unit shows neither end position.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_closed <= '0;
            aux_open   <= '1;
            for (int u = 0; u < NU; u++) cnt[u] <= 0;
        end else begin
            for (int u = 0; u < NU; u++) begin
                if (close_cmd[u] || open_cmd[u]) begin
                    if (stall[u] || cnt[u] < DELAY) begin
                        cnt[u]        <= cnt[u] + 1;
                        aux_closed[u] <= 1'b0;
                        aux_open[u]   <= 1'b0;
                    end else begin
                        aux_closed[u] <= !open_cmd[u];
                        aux_open[u]   <= open_cmd[u];
                    end
                end else begin
                    cnt[u] <= 0;
                end
            end
        end
    end
endmodule : sgcm_gear

// ==== tb/switchgear_control_manager_test.sv ====
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 2000) begin @(posedge clk); k++; end \
    if (k >= 2000) begin failures++; close_out(); end end
module switchgear_control_manager_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sgcm_pkg::*;

    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, seed = 32'h7;
    logic pready, pslverr;
    logic [NU-1:0] aux_c, aux_o, rdy = '0, rem = '0, ext_c = '0, ext_o = '0, trip = '0;
    logic [NU-1:0] stall = '0, close_cmd, open_cmd, ready_o, removed_o, earthed_o;
    logic [NU*NBLK-1:0] cblk = '0, oblk = '0;
    logic [2*NU-1:0] pos;
    logic [NR-1:0] relay;
    logic [7:0] seen;
    logic [32:0] q [$];
    logic [32:0] exp_rd;
    int failures = 0, n_compared = 0, k, n;

    sgcm_manager #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_closed_input(aux_c), .aux_open_input(aux_o),
        .ready_input(rdy), .removed_input(rem), .close_block_input(cblk),
        .open_block_input(oblk), .external_close_request(ext_c),
        .external_open_request(ext_o), .protection_trip(trip), .position_code(pos),
        .unit_ready(ready_o), .unit_removed(removed_o), .unit_earthed(earthed_o),
        .close_cmd(close_cmd), .open_cmd(open_cmd), .relay_out(relay));

    sgcm_gear gear (.clk(clk), .reset_n(reset_n), .close_cmd(close_cmd),
        .open_cmd(open_cmd), .stall(stall), .aux_closed(aux_c), .aux_open(aux_o));

    // Half period of 50 ns gives the 10 MHz clock.
    always #50 clk = ~clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // One APB transfer; an idle edge follows so the strobes never toggle in one step.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int kk;
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        kk = 0;
        do begin @(posedge clk); kk++; end while (pready !== 1'b1 && kk < 50);
        if (kk >= 50) begin failures++; close_out(); end
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] e);
        q.push_back({err, e});
        apb(a, 1'b0, 32'h0);
    endtask : rd

    // Collects every command bit raised over eight cycles.
    task automatic idle8();
        seen = '0;
        repeat (8) begin @(posedge clk); seen |= {open_cmd, close_cmd}; end
    endtask : idle8

    // Read results are matched against the oldest noted expectation.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (q.size() == 0) begin failures++; close_out(); end
            exp_rd = q.pop_front();
            `CHK({pslverr, prdata}, exp_rd)
        end
    end

    initial begin repeat (50000) @(posedge clk); failures++; close_out(); end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1;
        void'(xs());
        {rem, rdy} <= seed[7:0];
        @(posedge clk);
        rd(CFG_OFS, 0, 32'h11);
        rd(8'h20, 0, 32'h00c800c8);
        rd(8'h18, 1, 32'h0);
        rd(STATUS_OFS, 0, {16'h0, rem, rdy, 8'h55});
        apb(CFG_OFS, 1, 32'h852);
        rd(CFG_OFS, 0, 32'h11);
        rd(EVENT_OFS, 0, 32'h100);
        $display("reset and config guard done");
        apb(CFG_OFS, 1, 32'h853);
        apb(EVENT_OFS, 1, 32'h1ff);
        apb({RELAY_PAGE, 4'h0}, 1, 32'h21);
        rd(STATUS_OFS, 0, {12'h0, 4'h8, rem, rdy, 8'h55});
        `CHK({removed_o, ready_o, earthed_o}, {rem, rdy, 4'h8})
        for (int b = 0; b < NBLK; b++) begin
            cblk <= 12'h1 << b;
            apb(CMD_OFS, 1, 32'h1);
            idle8();
            `CHK(seen[0], 1'b0)
        end
        cblk <= '0;
        apb(CMD_OFS, 1, 32'h1);
        `WAIT(close_cmd[0])
        `CHK(relay, 4'h1)
        `WAIT(!close_cmd[0])
        @(posedge clk);
        `CHK(pos[1:0], POS_CLOSED)
        apb(USEL_OFS, 1, 32'h0);
        rd(UPOS_OFS, 0, {28'h0, rem[0], rdy[0], 2'h2});
        for (int b = 0; b < NBLK; b++) begin
            oblk <= 12'h1 << b;
            apb(CMD_OFS, 1, 32'h10);
            idle8();
            `CHK(seen[4], 1'b0)
        end
        oblk <= '0;
        rd(EVENT_OFS, 0, 32'h10);
        $display("blocking and manual close done");
        ext_o <= 4'h1;
        `WAIT(open_cmd[0])
        `CHK(relay, 4'h1)
        `WAIT(!open_cmd[0])
        ext_o <= 4'h0;
        @(posedge clk);
        `CHK(pos[1:0], POS_OPEN)
        ext_c <= 4'h4;
        `WAIT(close_cmd[2])
        ext_c <= 4'h8;
        trip <= 4'hc;
        apb(CMD_OFS, 1, 32'h20);
        idle8();
        `CHK({seen[7:5], seen[3]}, 4'h0)
        trip <= 4'h2;
        `WAIT(open_cmd[1])
        {trip, ext_c} <= '0;
        $display("external and trip done");
        apb(8'h20, 1, 32'h00c80001);
        apb(EVENT_OFS, 1, 32'h1ff);
        stall <= 4'h1;
        apb(CMD_OFS, 1, 32'h1);
        `WAIT(close_cmd[0])
        n = 0;
        while (close_cmd[0] && n < 100) begin @(posedge clk); n++; end
        `CHK(n >= 4 && n <= 12, 1'b1)
        @(posedge clk);
        `CHK(pos[1:0], POS_DISTURB)
        rd(EVENT_OFS, 0, 32'h1);
        $display("travel timeout done");
        close_out();
    end
endmodule : switchgear_control_manager_test
